// ### inc/flsg_pkg.sv
package flsg_pkg;
   // clock and timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PUW_NS        = 10000;
   localparam int PUW_CYC       = (PUW_NS * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
   localparam int CYCLE_NS      = 1000;
   localparam int CYCLE_CYC     = (CYCLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
   localparam logic [11:0] PUW_LAST   = 12'(PUW_CYC - 1);
   localparam logic [11:0] CYCLE_LAST = 12'(CYCLE_CYC - 1);

   // opcodes
   localparam logic [7:0] OP_ARM      = 8'h06;
   localparam logic [7:0] OP_DISARM   = 8'h04;
   localparam logic [7:0] OP_RD_STAT  = 8'h05;
   localparam logic [7:0] OP_WR_STAT  = 8'h01;
   localparam logic [7:0] OP_PAGE_WR  = 8'h02;
   localparam logic [7:0] OP_SECT     = 8'h20;
   localparam logic [7:0] OP_HALF     = 8'h52;
   localparam logic [7:0] OP_BLOCK    = 8'hD8;
   localparam logic [7:0] OP_CHIP_A   = 8'hC7;
   localparam logic [7:0] OP_CHIP_B   = 8'h60;
   localparam logic [7:0] OP_SLEEP    = 8'hB9;
   localparam logic [7:0] OP_WAKE     = 8'hAB;

   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_ARM  = 1;
   localparam int ST_BP0  = 2;
   localparam int ST_LOCK = 7;

   // reset values, erased byte and page size
   localparam logic [3:0] BP_RST    = 4'h0;
   localparam logic       LOCK_RST  = 1'b0;
   localparam logic [7:0] ERASED    = 8'hFF;
   localparam logic [8:0] PAGE_SIZE = 9'h100;

   typedef enum logic [2:0] {
      FLSG_PROG  = 3'b000,
      FLSG_SECT  = 3'b001,
      FLSG_HALF  = 3'b010,
      FLSG_BLOCK = 3'b011,
      FLSG_CHIP  = 3'b100
   } flsg_kind_t;

   typedef struct packed {
      flsg_kind_t  kind;
      logic [20:0] addr;
      logic [7:0]  data;
   } flsg_op_t;

   typedef enum logic [1:0] {
      SQ_IDLE  = 2'b00,
      SQ_ISSUE = 2'b01,
      SQ_WAIT  = 2'b10
   } flsg_state_t;
endpackage

// ### src/flsg_write_guard.sv
`timescale 1ns/1ps
// Summary of operation
// - while supply is low the whole device stays in reset.
// - write-type commands are rejected until the power-up write delay ends.
// - write arm latch starts cleared after power-up.
// - program, erase and status write need the latch set first.
// - latch clears itself when the internal cycle finishes.
// - write-type commands ending mid-byte are discarded.
// - protect values 1..5 guard blocks from the top end; 6 and 7 guard all.
// - protect values 10..14 guard blocks from the bottom end; 8, 9 and 15 guard all.
// - lock and protect bits change only by status write.
// - status write refused when lock bit set and protect pin low.
// - status bits: busy, latch, four protect, reserved, lock.
// - page write programs up to 256 bytes within one page.
// - erase fills sector, half block, block or chip with FFh.
// - busy flag shows while a status write, program or erase runs.
// - select low means active; standby only after cycles finish.
// - sleep command enters deep sleep until the wake command.
// - in deep sleep every command but wake is ignored.
// - opcode first after select falls, bits MSB first on clock rise.
// - address, data and dummy bytes follow; select rise ends it.
// - reads may end after any bit.
// - while busy only status read is honoured.
module flsg_write_guard
(
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   // serial pins
   input  wire logic               spi_clk,
   input  wire logic               spi_cs_n,
   input  wire logic               serial_io_line,
   input  wire logic               wp_n,
   output logic                    spi_so,
   output logic                    spi_so_oe,
   // array operation stream
   output flsg_pkg::flsg_op_t      arr_op,
   output logic                    arr_valid,
   input  wire logic               arr_ready,
   // status
   output logic [7:0]              status_byte,
   output logic                    deep_sleep_state,
   output logic                    standby,
   output logic                    write_lockout
);
   function automatic logic prot(input logic [3:0] bp, input logic [4:0] b);
      unique case (bp)
         4'h0: prot = 1'b0;
         4'h1: prot = (b >= 5'h1F);
         4'h2: prot = (b >= 5'h1E);
         4'h3: prot = (b >= 5'h1C);
         4'h4: prot = (b >= 5'h18);
         4'h5: prot = (b >= 5'h10);
         4'hA: prot = (b <= 5'h0F);
         4'hB: prot = (b <= 5'h17);
         4'hC: prot = (b <= 5'h1B);
         4'hD: prot = (b <= 5'h1D);
         4'hE: prot = (b <= 5'h1E);
         default: prot = 1'b1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage 1 is read only by stage 2
   logic [3:0] s1_r, s2_r;
   logic       clk_d_r, cs_d_r;
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         // idle pin levels, so no false edge follows reset
         s1_r    <= 4'hA;
         s2_r    <= 4'hA;
         clk_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
      end
      else
      begin
         s1_r    <= {wp_n, serial_io_line, spi_cs_n, spi_clk};
         s2_r    <= s1_r;
         clk_d_r <= s2_r[0];
         cs_d_r  <= s2_r[1];
      end
   logic sclk, cs_n, si, wp;
   assign sclk = s2_r[0];
   assign cs_n = s2_r[1];
   assign si   = s2_r[2];
   assign wp   = s2_r[3];
   logic clk_rise, clk_fall, cs_fall, cs_rise;
   assign clk_rise = sclk & ~clk_d_r & ~cs_n;
   assign clk_fall = ~sclk & clk_d_r & ~cs_n;
   assign cs_fall  = ~cs_n & cs_d_r;
   assign cs_rise  = cs_n & ~cs_d_r;

   ////////////////////////////////////////////////////////////////////////
   // frame receiver
   logic [7:0]  sh_r, sh_nxt, opc_r, opc_nxt, wdat_r, wdat_nxt;
   logic [7:0]  tx_r, tx_nxt;
   logic [2:0]  bit_r, bit_nxt;
   logic [3:0]  byte_r, byte_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic [8:0]  dcnt_r, dcnt_nxt;
   logic        rd_r, rd_nxt, so_r, so_nxt, oe_r, oe_nxt;
   logic        pb_we;
   logic [7:0]  pb_idx, bval;
   logic [7:0]  pbuf [0:255];
   logic        busy_r, wel_r, lock_r, sleep_r;
   logic [3:0]  bp_r;
   logic [7:0]  stat;
   assign stat = {lock_r, 1'b0, bp_r, wel_r, busy_r};

   always_comb
   begin
      sh_nxt   = sh_r;
      opc_nxt  = opc_r;
      wdat_nxt = wdat_r;
      tx_nxt   = tx_r;
      bit_nxt  = bit_r;
      byte_nxt = byte_r;
      addr_nxt = addr_r;
      dcnt_nxt = dcnt_r;
      rd_nxt   = rd_r;
      so_nxt   = so_r;
      pb_we    = 1'b0;
      pb_idx   = addr_r[7:0] + dcnt_r[7:0];
      bval     = {sh_r[6:0], si};
      if (cs_fall)
      begin
         bit_nxt  = 3'h0;
         byte_nxt = 4'h0;
         dcnt_nxt = 9'h000;
         rd_nxt   = 1'b0;
      end
      else if (clk_rise)
      begin
         sh_nxt  = bval;
         bit_nxt = bit_r + 3'h1;
         if (bit_r == 3'h7)
         begin
            if (byte_r != 4'hF)
               byte_nxt = byte_r + 4'h1;
            if (byte_r == 4'h0)
               opc_nxt = bval;
            else if (byte_r <= 4'h3)
               addr_nxt = {addr_r[15:0], bval};
            if (byte_r == 4'h1)
               wdat_nxt = bval;
            if (byte_r >= 4'h4 && opc_r == flsg_pkg::OP_PAGE_WR && !busy_r)
            begin
               pb_we = 1'b1;
               // length saturates, low bits keep wrapping in the page
               if (dcnt_r[8])
                  dcnt_nxt = {1'b1, dcnt_r[7:0] + 8'h01};
               else
                  dcnt_nxt = dcnt_r + 9'h001;
            end
            if ((byte_r == 4'h0 && bval == flsg_pkg::OP_RD_STAT && !sleep_r)
                || rd_r)
            begin
               rd_nxt = 1'b1;
               tx_nxt = stat;
            end
         end
      end
      else if (clk_fall && rd_r)
      begin
         so_nxt = tx_r[7];
         tx_nxt = {tx_r[6:0], 1'b0};
      end
      oe_nxt = rd_nxt & ~cs_n;
   end

   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         sh_r   <= 8'h00;
         opc_r  <= 8'h00;
         wdat_r <= 8'h00;
         tx_r   <= 8'h00;
         bit_r  <= 3'h0;
         byte_r <= 4'h0;
         addr_r <= 24'h000000;
         dcnt_r <= 9'h000;
         rd_r   <= 1'b0;
         so_r   <= 1'b0;
         oe_r   <= 1'b0;
      end
      else
      begin
         sh_r   <= sh_nxt;
         opc_r  <= opc_nxt;
         wdat_r <= wdat_nxt;
         tx_r   <= tx_nxt;
         bit_r  <= bit_nxt;
         byte_r <= byte_nxt;
         addr_r <= addr_nxt;
         dcnt_r <= dcnt_nxt;
         rd_r   <= rd_nxt;
         so_r   <= so_nxt;
         oe_r   <= oe_nxt;
      end

   // page data kept apart so a torn frame never reaches the array
   always_ff @(posedge core_clk)
      if (pb_we)
         pbuf[pb_idx] <= bval;

   ////////////////////////////////////////////////////////////////////////
   // command commit, sequencer and two-entry output buffer
   flsg_pkg::flsg_state_t st_r, st_nxt;
   flsg_pkg::flsg_op_t    e0_r, e0_nxt, e1_r, e1_nxt, cmd_r, cmd_nxt, push_d;
   logic        v0_r, v0_nxt, v1_r, v1_nxt, push_v;
   logic        busy_nxt, wel_nxt, lock_nxt, sleep_nxt, lko_r, lko_nxt;
   logic        stby_r, stby_nxt;
   logic [3:0]  bp_nxt;
   logic [11:0] tmr_r, tmr_nxt;
   logic [8:0]  icnt_r, icnt_nxt, ilen_r, ilen_nxt;
   logic        whole, blk_p, any_p, erase, chip;

   always_comb
   begin
      st_nxt    = st_r;
      busy_nxt  = busy_r;
      wel_nxt   = wel_r;
      bp_nxt    = bp_r;
      lock_nxt  = lock_r;
      sleep_nxt = sleep_r;
      lko_nxt   = lko_r;
      tmr_nxt   = tmr_r;
      cmd_nxt   = cmd_r;
      icnt_nxt  = icnt_r;
      ilen_nxt  = ilen_r;
      push_v    = 1'b0;
      push_d    = cmd_r;
      whole     = (bit_r == 3'h0);
      blk_p     = prot(bp_r, addr_r[20:16]);
      any_p     = (bp_r != 4'h0);
      chip      = (opc_r == flsg_pkg::OP_CHIP_A)
                  || (opc_r == flsg_pkg::OP_CHIP_B);
      erase     = (opc_r == flsg_pkg::OP_SECT) || (opc_r == flsg_pkg::OP_HALF)
                  || (opc_r == flsg_pkg::OP_BLOCK);
      if (lko_r)
      begin
         if (tmr_r == flsg_pkg::PUW_LAST)
         begin
            lko_nxt = 1'b0;
            tmr_nxt = 12'h000;
         end
         else
            tmr_nxt = tmr_r + 12'h001;
      end
      // anything not matched below leaves state alone
      if (cs_rise && byte_r != 4'h0 && !busy_r)
      begin
         if (sleep_r)
            sleep_nxt = (opc_r != flsg_pkg::OP_WAKE);
         else if (opc_r == flsg_pkg::OP_SLEEP && whole && byte_r == 4'h1)
            sleep_nxt = 1'b1;
         else if (opc_r == flsg_pkg::OP_DISARM && whole)
            wel_nxt = 1'b0;
         else if (opc_r == flsg_pkg::OP_ARM && whole && !lko_r)
            wel_nxt = 1'b1;
         else if (whole && !lko_r && wel_r)
         begin
            if (opc_r == flsg_pkg::OP_WR_STAT && byte_r >= 4'h2
                && !(lock_r && !wp))
            begin
               bp_nxt   = wdat_r[5:2];
               lock_nxt = wdat_r[flsg_pkg::ST_LOCK];
               busy_nxt = 1'b1;
               st_nxt   = flsg_pkg::SQ_WAIT;
            end
            else if (opc_r == flsg_pkg::OP_PAGE_WR && byte_r >= 4'h5
                     && !blk_p)
            begin
               busy_nxt = 1'b1;
               icnt_nxt = 9'h000;
               ilen_nxt = dcnt_r[8] ? flsg_pkg::PAGE_SIZE : dcnt_r;
               cmd_nxt  = '{flsg_pkg::FLSG_PROG, addr_r[20:0], 8'h00};
               st_nxt   = flsg_pkg::SQ_ISSUE;
            end
            else if ((erase && byte_r >= 4'h4 && !blk_p)
                     || (chip && !any_p))
            begin
               busy_nxt = 1'b1;
               icnt_nxt = 9'h000;
               ilen_nxt = 9'h001;
               cmd_nxt.addr = addr_r[20:0];
               cmd_nxt.data = flsg_pkg::ERASED;
               cmd_nxt.kind = chip ? flsg_pkg::FLSG_CHIP
                            : (opc_r == flsg_pkg::OP_SECT) ? flsg_pkg::FLSG_SECT
                            : (opc_r == flsg_pkg::OP_HALF) ? flsg_pkg::FLSG_HALF
                            : flsg_pkg::FLSG_BLOCK;
               st_nxt   = flsg_pkg::SQ_ISSUE;
            end
         end
      end
      unique case (st_r)
         flsg_pkg::SQ_IDLE:
            ;
         flsg_pkg::SQ_ISSUE:
         begin
            push_d = cmd_r;
            if (cmd_r.kind == flsg_pkg::FLSG_PROG)
            begin
               // stays inside the page: low address byte wraps
               push_d.addr = {cmd_r.addr[20:8], cmd_r.addr[7:0] + icnt_r[7:0]};
               push_d.data = pbuf[cmd_r.addr[7:0] + icnt_r[7:0]];
            end
            if (!v1_r) // buffer full stalls issue
            begin
               push_v   = 1'b1;
               icnt_nxt = icnt_r + 9'h001;
               if (icnt_nxt == ilen_r)
                  st_nxt = flsg_pkg::SQ_WAIT;
            end
         end
         flsg_pkg::SQ_WAIT:
            if (!v0_r)
            begin
               if (tmr_r == flsg_pkg::CYCLE_LAST)
               begin
                  tmr_nxt  = 12'h000;
                  busy_nxt = 1'b0;
                  wel_nxt  = 1'b0;
                  st_nxt   = flsg_pkg::SQ_IDLE;
               end
               else
                  tmr_nxt = tmr_r + 12'h001;
            end
         default:
            st_nxt = flsg_pkg::SQ_IDLE;
      endcase
      // buffer: pop first, then push into the first free slot
      e0_nxt = e0_r;
      e1_nxt = e1_r;
      v0_nxt = v0_r;
      v1_nxt = v1_r;
      if (v0_r && arr_ready)
      begin
         e0_nxt = e1_r;
         v0_nxt = v1_r;
         v1_nxt = 1'b0;
      end
      if (push_v && !v0_nxt)
      begin
         e0_nxt = push_d;
         v0_nxt = 1'b1;
      end
      else if (push_v)
      begin
         e1_nxt = push_d;
         v1_nxt = 1'b1;
      end
      stby_nxt = cs_n && !busy_nxt && !sleep_nxt;
   end

   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         st_r    <= flsg_pkg::SQ_IDLE;
         busy_r  <= 1'b0;
         wel_r   <= 1'b0;
         bp_r    <= flsg_pkg::BP_RST;
         lock_r  <= flsg_pkg::LOCK_RST;
         sleep_r <= 1'b0;
         lko_r   <= 1'b1;
         tmr_r   <= 12'h000;
         cmd_r   <= '0;
         icnt_r  <= 9'h000;
         ilen_r  <= 9'h000;
         e0_r    <= '0;
         e1_r    <= '0;
         v0_r    <= 1'b0;
         v1_r    <= 1'b0;
         stby_r  <= 1'b1;
      end
      else
      begin
         st_r    <= st_nxt;
         busy_r  <= busy_nxt;
         wel_r   <= wel_nxt;
         bp_r    <= bp_nxt;
         lock_r  <= lock_nxt;
         sleep_r <= sleep_nxt;
         lko_r   <= lko_nxt;
         tmr_r   <= tmr_nxt;
         cmd_r   <= cmd_nxt;
         icnt_r  <= icnt_nxt;
         ilen_r  <= ilen_nxt;
         e0_r    <= e0_nxt;
         e1_r    <= e1_nxt;
         v0_r    <= v0_nxt;
         v1_r    <= v1_nxt;
         stby_r  <= stby_nxt;
      end

   assign spi_so           = so_r;
   assign spi_so_oe        = oe_r;
   assign arr_op           = e0_r;
   assign arr_valid        = v0_r;
   assign status_byte      = stat;
   assign deep_sleep_state = sleep_r;
   assign standby          = stby_r;
   assign write_lockout    = lko_r;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   property p_lockout; lko_r |=> !$rose(wel_r) && !$rose(busy_r); endproperty
   a_lockout: assert property (p_lockout) else $error("arm in lockout");
   property p_arm_before; $rose(busy_r) |-> $past(wel_r); endproperty
   a_arm_before: assert property (p_arm_before) else $error("no arm");
   property p_self_clear; $fell(busy_r) |-> !wel_r; endproperty
   a_self_clear: assert property (p_self_clear) else $error("latch kept");
   property p_torn; cs_rise && bit_r != 3'h0 && !busy_r |=> !$rose(busy_r)
      && $stable(bp_r) && $stable(wel_r); endproperty
   a_torn: assert property (p_torn) else $error("torn frame acted");
   property p_locked; cs_rise && lock_r && !wp |=> $stable(bp_r);
   endproperty
   a_locked: assert property (p_locked) else $error("locked write");
   property p_sleep; sleep_r |=> !$rose(busy_r); endproperty
   a_sleep: assert property (p_sleep) else $error("work in sleep");
   property p_busy_ign; busy_r ##1 busy_r |-> $stable(bp_r) && wel_r;
   endproperty
   a_busy_ign: assert property (p_busy_ign) else $error("busy changed");
   property p_prot; arr_valid && arr_op.kind == flsg_pkg::FLSG_PROG
      |-> !prot(bp_r, arr_op.addr[20:16]); endproperty
   a_prot: assert property (p_prot) else $error("protected write");
   property p_stby; busy_r [*2] |-> !standby; endproperty
   a_stby: assert property (p_stby) else $error("standby while busy");
   property p_full; v1_r |-> v0_r; endproperty
   a_full: assert property (p_full) else $error("buffer hole");
   c_prog:  cover property ($rose(busy_r) && st_r == flsg_pkg::SQ_ISSUE);
   c_full:  cover property (v1_r && !arr_ready);
   c_sleep: cover property ($fell(sleep_r));
endmodule // flsg_write_guard

// ### testbench/flsg_host_model.sv
`timescale 1ns/1ps
module flsg_host_model
(
   // clock
   input  wire logic core_clk,
   // serial pins
   output logic      spi_clk,
   output logic      spi_cs_n,
   output logic      serial_io_line,
   input  wire logic spi_so,
   input  wire logic spi_so_oe
);
   initial
   begin
      spi_clk        = 1'b0;
      spi_cs_n       = 1'b1;
      serial_io_line = 1'b0;
   end

   // half of the 160 ns link period, aligned to the falling core edge
   task automatic half();
      repeat (16) @(negedge core_clk);
   endtask

   // mode 0: clock stands low outside frames
   task automatic frame(input logic [7:0] q[$], input int nbits,
                        output logic [7:0] rd);
      rd = 8'h00;
      @(negedge core_clk);
      spi_cs_n = 1'b0;
      for (int k = 0; k < nbits; k++)
      begin
         serial_io_line = q[k / 8][7 - (k % 8)];
         half();
         spi_clk = 1'b1;
         if (k >= 8 && k < 16)
            rd = {rd[6:0], spi_so & spi_so_oe};
         half();
         spi_clk = 1'b0;
      end
      half();
      spi_cs_n = 1'b1;
      // released line must not keep showing the last bit
      serial_io_line = ~serial_io_line;
      half();
   endtask
endmodule // flsg_host_model

// ### testbench/flsg_write_guard_tb.sv
`timescale 1ns/1ps
module flsg_write_guard_tb;
   logic               core_clk;
   logic               rst_b;
   logic               wp_n;
   logic               arr_ready;
   logic               spi_clk;
   logic               spi_cs_n;
   logic               serial_io_line;
   logic               spi_so;
   logic               spi_so_oe;
   flsg_pkg::flsg_op_t arr_op;
   logic               arr_valid;
   logic [7:0]         status_byte;
   logic               deep_sleep_state;
   logic               standby;
   logic               write_lockout;
   int                 err_total;
   int                 checked;
   logic [7:0]         rd;
   flsg_pkg::flsg_op_t op;

   flsg_write_guard uut (.core_clk(core_clk), .rst_b(rst_b),
      .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
      .serial_io_line(serial_io_line), .wp_n(wp_n), .spi_so(spi_so),
      .spi_so_oe(spi_so_oe), .arr_op(arr_op), .arr_valid(arr_valid),
      .arr_ready(arr_ready), .status_byte(status_byte),
      .deep_sleep_state(deep_sleep_state), .standby(standby),
      .write_lockout(write_lockout));

   flsg_host_model host (.core_clk(core_clk), .spi_clk(spi_clk),
      .spi_cs_n(spi_cs_n), .serial_io_line(serial_io_line),
      .spi_so(spi_so), .spi_so_oe(spi_so_oe));

   always #2.5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk_v(string name, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
         err_total++;
      end
   endtask

   task automatic chk_op(flsg_pkg::flsg_op_t exp, flsg_pkg::flsg_op_t got);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected arr_op: expected %h, seen %h", exp, got);
         err_total++;
      end
   endtask

   task automatic timeout(string name);
      $display("unexpected %s: expected done, seen timeout", name);
      err_total++;
      test_done();
   endtask

   task automatic send(logic [7:0] q[$], int nbits);
      host.frame(q, nbits, rd);
   endtask

   task automatic cmd(logic [7:0] b);
      send('{b}, 8);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 3000; i++)
      begin
         if (status_byte[0] === 1'b0)
            return;
         @(negedge core_clk);
      end
      timeout("busy");
   endtask

   // one op every two cycles; the buffer holds back the rest
   task automatic pop(output flsg_pkg::flsg_op_t got);
      for (int i = 0; i < 200; i++)
      begin
         @(negedge core_clk);
         if (arr_valid === 1'b1)
         begin
            got = arr_op;
            arr_ready = 1'b1;
            @(negedge core_clk);
            arr_ready = 1'b0;
            return;
         end
      end
      timeout("arr_valid");
   endtask

   task automatic no_op();
      int n;
      n = 0;
      repeat (60)
      begin
         @(negedge core_clk);
         if (arr_valid !== 1'b0)
            n++;
      end
      chk_v("refused op", 8'h00, 8'(n));
   endtask

   task automatic status_write_command(logic [7:0] v);
      cmd(flsg_pkg::OP_ARM);
      send('{flsg_pkg::OP_WR_STAT, v}, 16);
      wait_idle();
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_power_up();
      chk_v("status", 8'h00, status_byte);
      chk_v("lockout", 8'h01, 8'(write_lockout));
      chk_v("valid", 8'h00, 8'(arr_valid));
      rst_b = 1'b1;
      cmd(flsg_pkg::OP_ARM);
      chk_v("status", 8'h00, status_byte);
      for (int i = 0; i < 3000 && write_lockout !== 1'b0; i++)
         @(negedge core_clk);
      if (write_lockout !== 1'b0)
         timeout("lockout");
      chk_v("lockout", 8'h00, 8'(write_lockout));
      cmd(flsg_pkg::OP_ARM);
      chk_v("status", 8'h02, status_byte);
      cmd(flsg_pkg::OP_DISARM);
      chk_v("status", 8'h00, status_byte);
   endtask

   task automatic t_no_arm();
      send('{8'h02, 8'h00, 8'h00, 8'h10, 8'h55}, 40);
      no_op();
      chk_v("status", 8'h00, status_byte);
   endtask

   task automatic t_midbyte();
      cmd(flsg_pkg::OP_ARM);
      send('{8'h02, 8'h00, 8'h00, 8'h10, 8'h55}, 37);
      no_op();
      chk_v("status", 8'h02, status_byte);
      cmd(flsg_pkg::OP_DISARM);
   endtask

   task automatic t_page();
      logic [7:0] d [3];
      d = '{8'hA5, 8'h3C, 8'h0F};
      cmd(flsg_pkg::OP_ARM);
      send('{8'h02, 8'h00, 8'h00, 8'h10, d[0], d[1], d[2]}, 56);
      chk_v("busy", 8'h01, 8'(status_byte[0]));
      chk_v("standby", 8'h00, 8'(standby));
      // stalled stream keeps the cycle running
      cmd(flsg_pkg::OP_DISARM);
      send('{flsg_pkg::OP_RD_STAT, 8'h00}, 16);
      chk_v("read status", 8'h03, rd);
      chk_v("read enable", 8'h00, 8'(spi_so_oe));
      for (int i = 0; i < 3; i++)
      begin
         pop(op);
         chk_op('{flsg_pkg::FLSG_PROG, 21'(21'h10 + i), d[i]}, op);
      end
      wait_idle();
      chk_v("status", 8'h00, status_byte);
      chk_v("standby", 8'h01, 8'(standby));
   endtask

   task automatic t_erase_kinds();
      logic [7:0]           ops [5];
      flsg_pkg::flsg_kind_t kinds [5];
      ops = '{flsg_pkg::OP_SECT, flsg_pkg::OP_HALF, flsg_pkg::OP_BLOCK,
              flsg_pkg::OP_CHIP_A, flsg_pkg::OP_CHIP_B};
      kinds = '{flsg_pkg::FLSG_SECT, flsg_pkg::FLSG_HALF,
                flsg_pkg::FLSG_BLOCK, flsg_pkg::FLSG_CHIP,
                flsg_pkg::FLSG_CHIP};
      for (int i = 0; i < 5; i++)
      begin
         cmd(flsg_pkg::OP_ARM);
         if (i < 3)
            send('{ops[i], 8'h01, 8'h00, 8'h00}, 32);
         else
            cmd(ops[i]);
         pop(op);
         if (i < 3)
            chk_op('{kinds[i], 21'h010000, flsg_pkg::ERASED}, op);
         chk_v("kind", 8'(kinds[i]), 8'(op.kind));
         chk_v("fill", 8'hFF, op.data);
         wait_idle();
         chk_v("status", 8'h00, status_byte);
      end
   endtask

   // probe one block per level, on the edge of the guarded range
   task automatic t_protect();
      logic [4:0]  blk [16];
      logic [15:0] hit;
      logic [3:0]  bp;
      blk = '{31, 31, 29, 28, 23, 16, 0, 0, 31, 0, 16, 23, 28, 29, 31, 15};
      hit = 16'hABEA;
      for (int v = 0; v < 16; v++)
      begin
         bp = 4'(v);
         status_write_command({2'b00, bp, 2'b00});
         chk_v("status", {2'b00, bp, 2'b00}, status_byte);
         cmd(flsg_pkg::OP_ARM);
         send('{flsg_pkg::OP_BLOCK, 8'(blk[v]), 8'h00, 8'h00}, 32);
         if (hit[v])
         begin
            no_op();
            chk_v("status", {2'b00, bp, 2'b10}, status_byte);
         end
         else
         begin
            pop(op);
            chk_op('{flsg_pkg::FLSG_BLOCK, {blk[v], 16'h0000},
                     flsg_pkg::ERASED}, op);
            wait_idle();
         end
      end
      status_write_command(8'h00);
   endtask

   task automatic t_lock();
      wp_n = 1'b0;
      status_write_command(8'h80);
      chk_v("status", 8'h80, status_byte);
      cmd(flsg_pkg::OP_ARM);
      send('{flsg_pkg::OP_WR_STAT, 8'h00}, 16);
      repeat (20) @(negedge core_clk);
      chk_v("status", 8'h82, status_byte);
      wp_n = 1'b1;
      status_write_command(8'h00);
      chk_v("status", 8'h00, status_byte);
   endtask

   task automatic t_sleep();
      cmd(flsg_pkg::OP_SLEEP);
      chk_v("sleep", 8'h01, 8'(deep_sleep_state));
      cmd(flsg_pkg::OP_ARM);
      chk_v("status", 8'h00, status_byte);
      send('{flsg_pkg::OP_WAKE, 8'h00, 8'h00, 8'h00}, 32);
      chk_v("sleep", 8'h00, 8'(deep_sleep_state));
      cmd(flsg_pkg::OP_ARM);
      chk_v("status", 8'h02, status_byte);
      cmd(flsg_pkg::OP_DISARM);
   endtask

   // supply dip in mid-run: latch lost, lockout restarts
   task automatic t_reset();
      cmd(flsg_pkg::OP_ARM);
      rst_b = 1'b0;
      repeat (2) @(negedge core_clk);
      chk_v("status", 8'h00, status_byte);
      chk_v("lockout", 8'h01, 8'(write_lockout));
      rst_b = 1'b1;
      cmd(flsg_pkg::OP_ARM);
      chk_v("status", 8'h00, status_byte);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk  = 1'b0;
      rst_b     = 1'b0;
      wp_n      = 1'b1;
      arr_ready = 1'b0;
      err_total = 0;
      checked   = 0;
      repeat (4) @(negedge core_clk);
      t_power_up();
      t_no_arm();
      t_midbyte();
      t_page();
      t_erase_kinds();
      t_protect();
      t_lock();
      t_sleep();
      t_reset();
      test_done();
   end
endmodule // flsg_write_guard_tb
